// file: hdl/hbpm_map.svh
// constants for the host bus pin mode mapper
`ifndef HBPM_MAP_SVH
`define HBPM_MAP_SVH
`define HBPM_ADDR_W      18
`define HBPM_DATA_W      16
`define HBPM_MODE_W      3
`define HBPM_MODE_GEN1   3'h0
`define HBPM_MODE_GEN2   3'h1
`define HBPM_MODE_BSTART 3'h2
`define HBPM_MODE_STB16  3'h3
`define HBPM_MODE_STB32  3'h4
`define HBPM_MODE_BEA    3'h5
`define HBPM_MODE_BEB    3'h6
`define HBPM_LO_BYTE     7:0
`define HBPM_HI_BYTE     15:8
`endif

// file: hdl/hbpm_pkg.sv
// types for the host bus pin mode mapper
`include "hbpm_map.svh"
package hbpm_pkg;
  typedef enum logic [2:0] {
    HBPM_GEN1,
    HBPM_GEN2,
    HBPM_BSTART,
    HBPM_STB16,
    HBPM_STB32,
    HBPM_BEA,
    HBPM_BEB
  } hbpm_mode_t;
  typedef enum logic [1:0] {
    HBPM_IDLE,
    HBPM_WRITE,
    HBPM_READ
  } hbpm_state_t;
endpackage : hbpm_pkg

// file: hdl/hbpm_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module hbpm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // raw and filtered levels
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    for (int i = 0; i < W; i++)
    begin
      if (s2_r[i] == s3_r[i])
        q_nxt[i] = s2_r[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q_r  <= INIT;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign dout = q_r;
endmodule : hbpm_sync
`default_nettype wire

// file: hdl/hbpm_top.sv
// host bus pin mode mapper top
// ----------------------------------------
// Notes on behaviour
// - gen2 and strobe32 take low pin as a0
// - strobe16: low pin is lower byte strobe
// - address bits 17..1 from upper pins
// - data pins two-way, hi-z in reset
// - first write pin: low write enable
// - strobe32: first write pin is size bit
// - byte-enable modes: first pin enables 7:0
// - second write pin: high byte enable
// - second pin: upper or single data strobe
// - byte-enable modes: second pin enables 15:8
// - act on strobes only under chip select
// - space select picks buffer or registers
// - bus-start mode decodes direction early
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "hbpm_map.svh"
module hbpm_top (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // configuration straps
  input  wire logic [`HBPM_MODE_W-1:0]  mode_cfg,
  // host pins
  input  wire logic                     addr_low_bit_pin,
  input  wire logic [`HBPM_ADDR_W-1:1]  addr_upper_pins,
  input  wire logic [`HBPM_DATA_W-1:0]  host_data_pins_i,
  output var  logic [`HBPM_DATA_W-1:0]  host_data_pins_o,
  output var  logic                     host_data_pins_oe_n,
  input  wire logic                     write_strobe_low_n,
  input  wire logic                     write_strobe_high_n,
  input  wire logic                     read_strobe_n,
  input  wire logic                     rd_wr_dir,
  input  wire logic                     chip_select_n,
  input  wire logic                     space_select,
  // internal access port
  output var  logic                     acc_valid,
  output var  logic                     acc_write,
  output var  logic                     acc_mem,
  output var  logic [`HBPM_ADDR_W-1:0]  acc_addr,
  output var  logic [1:0]               acc_byte_en,
  output var  logic                     acc_size0,
  output var  logic [`HBPM_DATA_W-1:0]  acc_wdata,
  input  wire logic [`HBPM_DATA_W-1:0]  acc_rdata,
  output var  logic [`HBPM_MODE_W-1:0]  mode_active
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`HBPM_ADDR_W+`HBPM_DATA_W+5:0] strb_s;
  logic                                 a0_s;
  logic                                 cs_s;
  logic                                 wlo_s;
  logic                                 whi_s;
  logic                                 rd_s;
  logic                                 dir_s;
  logic                                 ms_s;
  logic [`HBPM_ADDR_W-1:1]              au_s;
  logic [`HBPM_DATA_W-1:0]              dat_s;

  hbpm_sync #(.W(`HBPM_ADDR_W+`HBPM_DATA_W+6), .INIT('1)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({addr_low_bit_pin, chip_select_n, write_strobe_low_n, write_strobe_high_n,
             read_strobe_n, rd_wr_dir, addr_upper_pins, host_data_pins_i,
             space_select}),
    .dout  (strb_s)
  );
  assign {a0_s, cs_s, wlo_s, whi_s, rd_s, dir_s, au_s, dat_s, ms_s} = strb_s;

  // ----------------------------------------
  // mode latch
  // ----------------------------------------
  hbpm_pkg::hbpm_mode_t mode_r;
  hbpm_pkg::hbpm_mode_t mode_nxt;
  logic                 held_r;
  logic                 held_nxt;

  always_comb
  begin
    mode_nxt = mode_r;
    held_nxt = 1'b1;
    if (!held_r)
      mode_nxt = hbpm_pkg::hbpm_mode_t'(mode_cfg);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= hbpm_pkg::HBPM_GEN1;
      held_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      held_r <= held_nxt;
    end
  end

  // ----------------------------------------
  // pin role decode
  // ----------------------------------------
  logic       wr_req;
  logic       rd_req;
  logic [1:0] be;
  logic       addr0;
  logic       size0;

  always_comb
  begin
    be     = 2'h0;
    addr0  = 1'b0;
    size0  = 1'b0;
    wr_req = 1'b0;
    rd_req = 1'b0;
    unique case (mode_r)
      hbpm_pkg::HBPM_GEN1, hbpm_pkg::HBPM_BSTART:
      begin
        be     = {~whi_s, ~wlo_s};
        wr_req = ~wlo_s | ~whi_s;
        rd_req = ~rd_s;
        if (mode_r == hbpm_pkg::HBPM_BSTART)
        begin
          wr_req = ~dir_s ? (~wlo_s | ~whi_s) : 1'b0;
          rd_req = dir_s & ~rd_s;
        end
      end
      hbpm_pkg::HBPM_GEN2:
      begin
        addr0  = a0_s;
        wr_req = ~wlo_s;
        rd_req = ~rd_s;
        be     = {~whi_s, ~a0_s};
      end
      hbpm_pkg::HBPM_STB16:
      begin
        be     = {~whi_s, ~a0_s};
        wr_req = (be != 2'h0) & ~dir_s;
        rd_req = (be != 2'h0) & dir_s;
      end
      hbpm_pkg::HBPM_STB32:
      begin
        addr0  = a0_s;
        size0  = wlo_s;
        be     = ~whi_s ? 2'h3 : 2'h0;
        wr_req = ~whi_s & ~dir_s;
        rd_req = ~whi_s & dir_s;
      end
      hbpm_pkg::HBPM_BEA, hbpm_pkg::HBPM_BEB:
      begin
        be     = {~whi_s, ~wlo_s};
        wr_req = ~wlo_s | ~whi_s;
        rd_req = ~rd_s;
      end
      default:
      begin
        be = 2'h0;
      end
    endcase
    if (cs_s)
    begin
      wr_req = 1'b0;
      rd_req = 1'b0;
    end
  end

  // ----------------------------------------
  // access sequencing
  // ----------------------------------------
  hbpm_pkg::hbpm_state_t      st_r;
  hbpm_pkg::hbpm_state_t      st_nxt;
  logic                       val_r, val_nxt;
  logic                       wr_r, wr_nxt;
  logic                       mem_r, mem_nxt;
  logic [`HBPM_ADDR_W-1:0]    addr_r, addr_nxt;
  logic [1:0]                 be_r, be_nxt;
  logic                       sz_r, sz_nxt;
  logic [`HBPM_DATA_W-1:0]    wd_r, wd_nxt;
  logic [`HBPM_DATA_W-1:0]    do_r, do_nxt;
  logic                       oe_n_r, oe_n_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    val_nxt  = 1'b0;
    wr_nxt   = wr_r;
    mem_nxt  = mem_r;
    addr_nxt = addr_r;
    be_nxt   = be_r;
    sz_nxt   = sz_r;
    wd_nxt   = wd_r;
    do_nxt   = do_r;
    oe_n_nxt = 1'b1;
    unique case (st_r)
      hbpm_pkg::HBPM_IDLE:
      begin
        if (wr_req || rd_req)
        begin
          st_nxt   = wr_req ? hbpm_pkg::HBPM_WRITE : hbpm_pkg::HBPM_READ;
          val_nxt  = 1'b1;
          wr_nxt   = wr_req;
          mem_nxt  = ms_s;
          addr_nxt = {au_s, addr0};
          be_nxt   = be;
          sz_nxt   = size0;
          wd_nxt   = dat_s;
        end
      end
      hbpm_pkg::HBPM_WRITE:
      begin
        if (!wr_req)
          st_nxt = hbpm_pkg::HBPM_IDLE;
      end
      hbpm_pkg::HBPM_READ:
      begin
        oe_n_nxt = ~rd_req;
        do_nxt   = acc_rdata;
        if (!rd_req)
          st_nxt = hbpm_pkg::HBPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r   <= hbpm_pkg::HBPM_IDLE;
      val_r  <= 1'b0;
      wr_r   <= 1'b0;
      mem_r  <= 1'b0;
      addr_r <= '0;
      be_r   <= 2'h0;
      sz_r   <= 1'b0;
      wd_r   <= '0;
      do_r   <= '0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      st_r   <= st_nxt;
      val_r  <= val_nxt;
      wr_r   <= wr_nxt;
      mem_r  <= mem_nxt;
      addr_r <= addr_nxt;
      be_r   <= be_nxt;
      sz_r   <= sz_nxt;
      wd_r   <= wd_nxt;
      do_r   <= do_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign acc_valid           = val_r;
  assign acc_write           = wr_r;
  assign acc_mem             = mem_r;
  assign acc_addr            = addr_r;
  assign acc_byte_en         = be_r;
  assign acc_size0           = sz_r;
  assign acc_wdata           = wd_r;
  assign host_data_pins_o    = do_r;
  assign host_data_pins_oe_n = oe_n_r;
  assign mode_active         = mode_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cs_gates_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_s |=> !val_r) else $error("access taken without chip select");
  mode_fixed_a: assert property (@(posedge mclk) disable iff (!rst_n)
    held_r && $past(held_r) |-> $stable(mode_r)) else $error("mode changed after reset");
  addr_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
    val_r |-> addr_r[`HBPM_ADDR_W-1:1] == $past(au_s))
    else $error("upper address not captured");
  addr_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    val_r && mode_r != hbpm_pkg::HBPM_GEN2 && mode_r != hbpm_pkg::HBPM_STB32
    |-> !addr_r[0]) else $error("low address bit used in wrong mode");
  data_hiz_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(rst_n) |-> oe_n_r) else $error("data driven out of reset");
  read_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !oe_n_r |-> $past(st_r) == hbpm_pkg::HBPM_READ) else $error("drive outside read");
  space_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    val_r |-> mem_r == $past(ms_s)) else $error("space select lost");
  be_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    val_r && (mode_r == hbpm_pkg::HBPM_BEA || mode_r == hbpm_pkg::HBPM_BEB)
    |-> be_r == {~$past(whi_s), ~$past(wlo_s)}) else $error("byte enables wrong");
  stb32_be_a: assert property (@(posedge mclk) disable iff (!rst_n)
    val_r && mode_r == hbpm_pkg::HBPM_STB32 |-> be_r == 2'h3)
    else $error("single strobe lanes wrong");
endmodule : hbpm_top
`default_nettype wire

// file: sim/hbpm_host_model.sv
// host processor bus model driving the device pins
`timescale 1ns/1ps
`default_nettype none
`include "hbpm_map.svh"
module hbpm_host_model (
  // clock and latched mode
  input  wire logic        mclk,
  input  wire logic [2:0]  mode,
  // resolved data bus
  input  wire logic [15:0] bus,
  // host pins
  output var  logic        a0_pin,
  output var  logic [17:1] au_pins,
  output var  logic [15:0] dq,
  output var  logic        wsl_n,
  output var  logic        wsh_n,
  output var  logic        rd_n,
  output var  logic        rw_dir,
  output var  logic        cs_n,
  output var  logic        sp
);
  logic g2, s16, s32;
  assign g2  = mode == `HBPM_MODE_GEN2;
  assign s16 = mode == `HBPM_MODE_STB16;
  assign s32 = mode == `HBPM_MODE_STB32;
  initial
  begin
    {a0_pin, au_pins, dq, sp} = '0;
    {wsl_n, wsh_n, rd_n, rw_dir, cs_n} = 5'h1F;
  end
  // one bus cycle, strobes held for hold edges
  task automatic access(input logic wr, input logic [17:0] a, input logic [1:0] be,
                        input logic [15:0] d, input logic spc, input logic s0,
                        input logic cs, input int hold, output logic [15:0] q);
    @(posedge mclk);
    #1;
    au_pins = a[17:1];
    sp      = spc;
    dq      = wr ? d : ~d;
    cs_n    = !cs;
    a0_pin  = (g2 || s32) ? a[0] : (s16 ? !be[0] : 1'b0);
    wsl_n   = g2 ? !wr : (s16 ? 1'b1 : (s32 ? s0 : !(wr && be[0])));
    wsh_n   = s32 ? 1'b0 : !((wr || g2 || s16) && be[1]);
    rd_n    = wr || s16 || s32;
    rw_dir  = (s16 || s32 || mode == `HBPM_MODE_BSTART) ? !wr : 1'b1;
    repeat (hold) @(posedge mclk);
    q = bus;
    #1;
    {wsl_n, wsh_n, rd_n, rw_dir, cs_n} = 5'h1F;
    a0_pin = s16;
    dq     = ~dq;
    repeat (8) @(posedge mclk);
    #1;
  endtask : access
endmodule : hbpm_host_model
`default_nettype wire

// file: sim/host_bus_pin_mode_mapper_tb.sv
// self-checking bench for the host bus pin mode mapper
`timescale 1ns/1ps
`default_nettype none
`include "hbpm_map.svh"
module host_bus_pin_mode_mapper_tb;
  typedef struct {
    logic w; logic m; logic [17:0] a; logic [1:0] be; logic s; logic [15:0] d; logic [1:0] k;
  } hbpm_exp_t;
  logic        mclk, rst_n, a0, wsl_n, wsh_n, rd_n, rw_dir, cs_n, sp, oe_n;
  logic        acc_valid, acc_write, acc_mem, acc_size0;
  logic [2:0]  mode_cfg, mode_active, m;
  logic [17:1] au;
  logic [17:0] acc_addr;
  logic [15:0] p_dq, din, dout, acc_wdata, acc_rdata;
  logic [1:0]  acc_byte_en;
  int          failures, total_checks;
  hbpm_exp_t   exp_q[$];
  hbpm_exp_t   e;
  assign din = (oe_n === 1'b0) ? dout : p_dq;
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  hbpm_top dut_u (.mclk(mclk), .rst_n(rst_n), .mode_cfg(mode_cfg), .addr_low_bit_pin(a0),
    .addr_upper_pins(au), .host_data_pins_i(din), .host_data_pins_o(dout),
    .host_data_pins_oe_n(oe_n), .write_strobe_low_n(wsl_n), .write_strobe_high_n(wsh_n),
    .read_strobe_n(rd_n), .rd_wr_dir(rw_dir), .chip_select_n(cs_n), .space_select(sp),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_mem(acc_mem), .acc_addr(acc_addr),
    .acc_byte_en(acc_byte_en), .acc_size0(acc_size0), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .mode_active(mode_active));
  hbpm_host_model host_u (.mclk(mclk), .mode(m), .bus(din), .a0_pin(a0), .au_pins(au),
    .dq(p_dq), .wsl_n(wsl_n), .wsh_n(wsh_n), .rd_n(rd_n), .rw_dir(rw_dir), .cs_n(cs_n),
    .sp(sp));
  task automatic check(input logic [17:0] seen, input logic [17:0] expv);
    total_checks++;
    if (seen !== expv)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // access monitor against expected queue
  // ----------------------------------------
  always @(posedge mclk)
    if (acc_valid === 1'b1)
    begin
      check(exp_q.size() > 0, 1);
      if (exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        check(acc_write, e.w);
        check(acc_mem, e.m);
        check(acc_addr[17:1], e.a[17:1]);
        if (e.k[0])
          check(acc_addr[0], e.a[0]);
        if (e.k[1])
          check(acc_size0, e.s);
        if (e.w)
          check(acc_byte_en, e.be);
        if (e.w)
          check(acc_wdata, e.d);
      end
    end
  task automatic do_acc(input logic wr, input logic cs, input int hold);
    hbpm_exp_t   x;
    logic [15:0] q;
    x.a = 18'($urandom);
    x.d = 16'($urandom);
    x.be = 2'($urandom_range(3, 1));
    x.m = 1'($urandom);
    x.s = 1'($urandom);
    x.w = wr;
    x.k = {m == `HBPM_MODE_STB32, m == `HBPM_MODE_STB32 || m == `HBPM_MODE_GEN2};
    acc_rdata = 16'($urandom);
    if (m == `HBPM_MODE_STB32)
      x.be = 2'h3;
    if (m == `HBPM_MODE_GEN2)
      x.be = {x.be[1], ~x.a[0]};
    if (cs && hold > 1 && m != 3'h7)
      exp_q.push_back(x);
    host_u.access(wr, x.a, x.be, x.d, x.m, x.s, cs, hold, q);
    check(exp_q.size(), 0);
    if (!wr && cs && m != 3'h7)
      check(q, acc_rdata);
    check(oe_n, 1);
  endtask : do_acc
  initial
  begin
    rst_n = 1'b0;
    mode_cfg = 3'h0;
    acc_rdata = 16'h0000;
    failures = 0;
    total_checks = 0;
    m = 3'h0;
    void'($urandom(8));
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1;
      m = 3'(i);
      rst_n = 1'b0;
      mode_cfg = m;
      repeat (3) @(posedge mclk);
      #1;
      check(oe_n, 1);
      rst_n = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      mode_cfg = ~m;
      check(mode_active, m);
      repeat (4) do_acc(1'b1, 1'b1, 10);
      do_acc(1'b0, 1'b1, 10);
      do_acc(1'b1, 1'b0, 10);
      do_acc(1'b1, 1'b1, 1);
      check(mode_active, m);
    end
    final_report;
  end
  initial
  begin
    repeat (8000) @(posedge mclk);
    failures++;
    final_report;
  end
endmodule : host_bus_pin_mode_mapper_tb
`default_nettype wire
